// ==== core/panel_cmd_pkg.sv ====
// Constants shared by the command decoder device end and the host command end
// Functional notes
// - Swap bit exchanges red and blue on writes
// - Swap pairs gamma as red-green and blue
// - Status read returns dummy then status byte
// - Status read is no-op when pixel port busy on the parallel interface
// - Status byte bit layout, bits 2..1 zero
// - Window command loads four 9-bit bounds
// - Exit external vsync synchronised mode
// - Enter external vsync synchronised mode
// - Regulator command: ten bytes, last three ignored
// - Host writes regulator values only while display is off
// - Regulator values apply after sleep-exit executes
// - First regulator byte: enable, triple, high reference
// - Source level from own code or gamma code
// - Offset code 11 is prohibited
// - Host keeps level codes in documented ranges
// - Host writes correction byte per interface type
// - Module byte two bit 0 picks lookup table
// - Module byte two bit 4 picks readback type
// - Sequence-shortening test bit stays zero
// - Effective orientation is control xor definition, bits 2..1 forced zero
package panel_cmd_pkg;
  localparam logic [7:0] CMD_NONE         = 8'h00;
  localparam logic [7:0] CMD_ORIENT_DEF   = 8'hb8;
  localparam logic [7:0] CMD_STATUS_READ  = 8'hb9;
  localparam logic [7:0] CMD_PIXEL_WINDOW = 8'hbb;
  localparam logic [7:0] CMD_VSYNC_EXIT   = 8'hbc;
  localparam logic [7:0] CMD_VSYNC_ENTER  = 8'hbd;
  localparam logic [7:0] CMD_REG_LEVEL    = 8'hbe;
  localparam logic [7:0] CMD_MODULE_DEF   = 8'hc0;

  localparam logic [3:0] NPAR_ORIENT_DEF  = 4'h1;
  localparam logic [3:0] NPAR_WINDOW      = 4'h8;
  localparam logic [3:0] NPAR_REG_LEVEL   = 4'ha;
  localparam logic [3:0] NPAR_MODULE_DEF  = 4'h5;
  localparam logic [3:0] PIDX_MAX         = 4'hf;

  localparam int         SWAP_BIT         = 2;
  localparam logic [7:0] ORIENT_XOR_MASK  = 8'hf9;
  localparam logic [7:0] STATUS_MASK      = 8'hf9;
  localparam logic [7:0] STATUS_DUMMY     = 8'h00;

  localparam int         LDO_EN_BIT       = 0;
  localparam int         TRIPLE_BIT       = 1;
  localparam int         LDO_HIGH_BIT     = 2;
  localparam int         SRC_SEL_BIT      = 7;
  localparam logic [1:0] OFFSET_PROHIBIT  = 2'h3;
  localparam logic [7:0] COMH_CODE_MAX    = 8'h96;
  localparam logic [7:0] LEVEL_CODE_MAX   = 8'h1f;

  localparam int         LUT_BIT          = 0;
  localparam int         READBACK_BIT     = 4;
  localparam int         SEQ_SHORT_BIT    = 0;
  localparam logic [7:0] CORR_PARALLEL    = 8'h0e;
  localparam logic [7:0] CORR_SERIAL      = 8'h0f;

  localparam logic [7:0] RESET_ORIENT_DEF = 8'h00;
  localparam logic [8:0] RESET_WIN_LO     = 9'h000;
  localparam logic [8:0] RESET_WIN_PAGE   = 9'h0ef;
  localparam logic [8:0] RESET_WIN_COL    = 9'h13f;
  localparam logic [7:0] RESET_REG_BYTE   = 8'h00;
  localparam logic [7:0] RESET_CORR       = 8'h00;

  // Parameter bytes a command accepts; anything beyond is dropped
  function automatic logic [3:0] param_count(input logic [7:0] cmd);
    if (cmd == CMD_ORIENT_DEF) param_count = NPAR_ORIENT_DEF;
    else if (cmd == CMD_PIXEL_WINDOW) param_count = NPAR_WINDOW;
    else if (cmd == CMD_REG_LEVEL) param_count = NPAR_REG_LEVEL;
    else if (cmd == CMD_MODULE_DEF) param_count = NPAR_MODULE_DEF;
    else param_count = 4'h0;
  endfunction
endpackage

// ==== core/panel_cmd_if.sv ====
// Command link between host end and panel driver decoder end
`timescale 1ns/1ps
`default_nettype none
interface panel_cmd_if;
  logic       wr;
  logic       rd;
  logic       cmd_param_select;
  logic [7:0] host_d;
  logic       host_d_oe;
  logic [7:0] dev_d;
  logic       dev_d_oe;

  modport device_end (
    input  wr, rd, cmd_param_select, host_d, host_d_oe,
    output dev_d, dev_d_oe
  );
  modport host_end (
    output wr, rd, cmd_param_select, host_d, host_d_oe,
    input  dev_d, dev_d_oe
  );
endinterface
`default_nettype wire

// ==== core/rb_swap_unit.sv ====
// Red/blue exchange stage on the frame-memory write path
`timescale 1ns/1ps
`default_nettype none
module rb_swap_unit (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_swap,
  input  wire logic        i_valid,
  input  wire logic [23:0] i_pixel,
  output logic             o_valid,
  output logic [23:0]      o_pixel
);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_pixel <= 24'h000000;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        // Stored order is already swapped, so reads need no reverse path
        o_pixel <= i_swap ? {i_pixel[7:0], i_pixel[15:8], i_pixel[23:16]} : i_pixel;
      end
    end
  end
endmodule // rb_swap_unit
`default_nettype wire

// ==== core/panel_cmd_device.sv ====
// Panel driver setup command decoder, device end of the command link
`timescale 1ns/1ps
`default_nettype none
module panel_cmd_device (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  panel_cmd_if.device_end  link,
  input  wire logic        i_pixel_port_active,
  input  wire logic        i_parallel_if_sel,
  input  wire logic [7:0]  i_status_src,
  input  wire logic        i_sleep_exit_done,
  input  wire logic [7:0]  i_orient_ctrl,
  input  wire logic        i_wr_pixel_valid,
  input  wire logic [23:0] i_wr_pixel,
  output logic             o_mem_pixel_valid,
  output logic [23:0]      o_mem_pixel,
  output logic [7:0]       o_orient_eff,
  output logic             o_rb_swap,
  output logic             o_gamma_rg_b,
  output logic [8:0]       o_win_start_page,
  output logic [8:0]       o_win_start_col,
  output logic [8:0]       o_win_end_page,
  output logic [8:0]       o_win_end_col,
  output logic             o_ext_vsync_mode,
  output logic             o_main_ref_en,
  output logic             o_boost_triple,
  output logic             o_main_ref_high,
  output logic             o_src_from_gamma,
  output logic [1:0]       o_src_offset,
  output logic [4:0]       o_src_code,
  output logic [7:0]       o_comh_code,
  output logic [4:0]       o_comw_code,
  output logic [4:0]       o_gamma_gen_code,
  output logic [4:0]       o_third_boost_code,
  output logic [4:0]       o_fourth_boost_code,
  output logic [7:0]       o_ic_correction,
  output logic             o_lut_262k,
  output logic             o_readback_262k,
  output logic             o_seq_short
);
  logic [7:0] cmd_reg;
  logic [3:0] pidx_reg;
  logic [7:0] orient_def_reg;
  logic       status_armed_reg;
  logic       status_phase_reg;
  logic [7:0] dev_d_reg;
  logic       dev_d_oe_reg;
  logic [7:0] pend_reg [0:6];
  logic [7:0] act_reg  [0:6];
  logic       cmd_wr;
  logic       par_wr;

  assign cmd_wr = link.wr && !link.cmd_param_select;
  assign par_wr = link.wr && link.cmd_param_select
                  && (pidx_reg < panel_cmd_pkg::param_count(cmd_reg));

  // Command byte and parameter position
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmd_reg  <= panel_cmd_pkg::CMD_NONE;
      pidx_reg <= 4'h0;
    end else if (cmd_wr) begin
      cmd_reg  <= link.host_d;
      pidx_reg <= 4'h0;
    end else if (link.wr && pidx_reg != panel_cmd_pkg::PIDX_MAX) begin
      pidx_reg <= pidx_reg + 4'h1;
    end
  end

  // Orientation definition and red/blue swap
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      orient_def_reg <= panel_cmd_pkg::RESET_ORIENT_DEF;
    end else if (par_wr && cmd_reg == panel_cmd_pkg::CMD_ORIENT_DEF) begin
      orient_def_reg <= link.host_d;
    end
  end

  assign o_rb_swap    = orient_def_reg[panel_cmd_pkg::SWAP_BIT];
  // Gamma pairing and the red/blue order of pixels written to memory both follow the swap bit
  assign o_gamma_rg_b = o_rb_swap;
  assign o_orient_eff = (i_orient_ctrl ^ orient_def_reg)
                        & panel_cmd_pkg::ORIENT_XOR_MASK;

  rb_swap_unit u_swap (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_swap  (o_rb_swap),
    .i_valid (i_wr_pixel_valid),
    .i_pixel (i_wr_pixel),
    .o_valid (o_mem_pixel_valid),
    .o_pixel (o_mem_pixel)
  );

  // Pixel port window, upper byte carries bit 8 in bit 0
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_win_start_page <= panel_cmd_pkg::RESET_WIN_LO;
      o_win_start_col  <= panel_cmd_pkg::RESET_WIN_LO;
      o_win_end_page   <= panel_cmd_pkg::RESET_WIN_PAGE;
      o_win_end_col    <= panel_cmd_pkg::RESET_WIN_COL;
    end else if (par_wr && cmd_reg == panel_cmd_pkg::CMD_PIXEL_WINDOW) begin
      case (pidx_reg)
        4'h0: o_win_start_page[8]   <= link.host_d[0];
        4'h1: o_win_start_page[7:0] <= link.host_d;
        4'h2: o_win_start_col[8]    <= link.host_d[0];
        4'h3: o_win_start_col[7:0]  <= link.host_d;
        4'h4: o_win_end_page[8]     <= link.host_d[0];
        4'h5: o_win_end_page[7:0]   <= link.host_d;
        4'h6: o_win_end_col[8]      <= link.host_d[0];
        default: o_win_end_col[7:0] <= link.host_d;
      endcase
    end
  end

  // External vsync synchronised display mode
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ext_vsync_mode <= 1'b0;
    end else if (cmd_wr && link.host_d == panel_cmd_pkg::CMD_VSYNC_ENTER) begin
      o_ext_vsync_mode <= 1'b1;
    end else if (cmd_wr && link.host_d == panel_cmd_pkg::CMD_VSYNC_EXIT) begin
      o_ext_vsync_mode <= 1'b0;
    end
  end

  // Regulator levels: pending copy, made active on sleep exit
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 7; i++) begin
        pend_reg[i] <= panel_cmd_pkg::RESET_REG_BYTE;
      end
    end else if (par_wr && cmd_reg == panel_cmd_pkg::CMD_REG_LEVEL && pidx_reg < 4'h7) begin
      pend_reg[pidx_reg[2:0]] <= link.host_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 7; i++) begin
        act_reg[i] <= panel_cmd_pkg::RESET_REG_BYTE;
      end
    end else if (i_sleep_exit_done) begin
      for (int i = 0; i < 7; i++) begin
        act_reg[i] <= pend_reg[i];
      end
    end
  end

  assign o_main_ref_en      = act_reg[0][panel_cmd_pkg::LDO_EN_BIT];
  assign o_boost_triple     = act_reg[0][panel_cmd_pkg::TRIPLE_BIT];
  // High reference only has meaning with the tripler running
  assign o_main_ref_high    = act_reg[0][panel_cmd_pkg::LDO_HIGH_BIT] && o_boost_triple;
  assign o_src_from_gamma   = act_reg[1][panel_cmd_pkg::SRC_SEL_BIT];
  // Prohibited offset code is passed through; the host end keeps it out
  assign o_src_offset       = act_reg[1][6:5];
  assign o_src_code         = o_src_from_gamma ? act_reg[4][4:0] : act_reg[1][4:0];
  assign o_comh_code        = act_reg[2];
  assign o_comw_code        = act_reg[3][4:0];
  assign o_gamma_gen_code   = act_reg[4][4:0];
  assign o_third_boost_code = act_reg[5][4:0];
  assign o_fourth_boost_code = act_reg[6][4:0];

  // Module definition
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ic_correction <= panel_cmd_pkg::RESET_CORR;
      o_lut_262k      <= 1'b0;
      o_readback_262k <= 1'b0;
      o_seq_short     <= 1'b0;
    end else if (par_wr && cmd_reg == panel_cmd_pkg::CMD_MODULE_DEF) begin
      if (pidx_reg == 4'h0) begin
        o_ic_correction <= link.host_d;
      end else if (pidx_reg == 4'h1) begin
        o_lut_262k      <= link.host_d[panel_cmd_pkg::LUT_BIT];
        o_readback_262k <= link.host_d[panel_cmd_pkg::READBACK_BIT];
      end else if (pidx_reg == 4'h2) begin
        o_seq_short     <= link.host_d[panel_cmd_pkg::SEQ_SHORT_BIT];
      end
    end
  end

  // Status read: dummy byte, then status byte, then nothing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_armed_reg <= 1'b0;
      status_phase_reg <= 1'b0;
    end else if (cmd_wr) begin
      status_armed_reg <= (link.host_d == panel_cmd_pkg::CMD_STATUS_READ)
                          && !(i_pixel_port_active && i_parallel_if_sel);
      status_phase_reg <= 1'b0;
    end else if (link.rd && status_armed_reg) begin
      status_phase_reg <= 1'b1;
      status_armed_reg <= !status_phase_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dev_d_reg    <= 8'h00;
      dev_d_oe_reg <= 1'b0;
    end else begin
      dev_d_oe_reg <= link.rd && status_armed_reg;
      if (link.rd && status_armed_reg) begin
        dev_d_reg <= status_phase_reg ? (i_status_src & panel_cmd_pkg::STATUS_MASK)
                                      : panel_cmd_pkg::STATUS_DUMMY;
      end
    end
  end

  assign link.dev_d    = dev_d_reg;
  assign link.dev_d_oe = dev_d_oe_reg;
endmodule // panel_cmd_device
`default_nettype wire

// ==== core/panel_cmd_host.sv ====
// Host end of the command link: issues bytes and reads, screens illegal values
`timescale 1ns/1ps
`default_nettype none
module panel_cmd_host (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  panel_cmd_if.host_end   link,
  input  wire logic       i_req_valid,
  input  wire logic       i_req_read,
  input  wire logic       i_req_param,
  input  wire logic [7:0] i_req_byte,
  input  wire logic       i_serial_if,
  input  wire logic       i_display_on,
  output logic            o_ready,
  output logic            o_reject,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data
);
  typedef enum logic [1:0] {H_IDLE, H_RD, H_CAP} host_state_e;

  host_state_e state_reg;
  logic [7:0]  cmd_reg;
  logic [3:0]  pidx_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic        sel_reg;
  logic [7:0]  d_reg;
  logic        bad;
  logic [7:0]  out_byte;
  logic        take;

  assign o_ready = (state_reg == H_IDLE);
  assign take    = i_req_valid && o_ready;

  // Screening and substitution of the outgoing parameter byte
  always_comb begin
    bad      = 1'b0;
    out_byte = i_req_byte;
    if (i_req_param && cmd_reg == panel_cmd_pkg::CMD_REG_LEVEL) begin
      bad = i_display_on;
      if (pidx_reg == 4'h1 && i_req_byte[6:5] == panel_cmd_pkg::OFFSET_PROHIBIT) begin
        bad = 1'b1;
      end
      if (pidx_reg == 4'h2 && i_req_byte > panel_cmd_pkg::COMH_CODE_MAX) begin
        bad = 1'b1;
      end
      if (pidx_reg > 4'h2 && pidx_reg < 4'h7 && i_req_byte > panel_cmd_pkg::LEVEL_CODE_MAX) begin
        bad = 1'b1;
      end
    end
    if (i_req_param && cmd_reg == panel_cmd_pkg::CMD_MODULE_DEF) begin
      if (pidx_reg == 4'h0) begin
        out_byte = i_serial_if ? panel_cmd_pkg::CORR_SERIAL
                               : panel_cmd_pkg::CORR_PARALLEL;
      end else if (pidx_reg == 4'h2) begin
        out_byte[panel_cmd_pkg::SEQ_SHORT_BIT] = 1'b0;
      end
    end
  end

  // Tracks command and parameter position the same way the decoder does
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmd_reg  <= panel_cmd_pkg::CMD_NONE;
      pidx_reg <= 4'h0;
    end else if (take && !i_req_read && !i_req_param) begin
      cmd_reg  <= i_req_byte;
      pidx_reg <= 4'h0;
    end else if (take && !i_req_read && !bad && pidx_reg != panel_cmd_pkg::PIDX_MAX) begin
      // A refused byte never reaches the decoder, so it must not use a slot here either;
      // otherwise later bytes are screened against the wrong field
      pidx_reg <= pidx_reg + 4'h1;
    end
  end

  // Link strobes and data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_reg   <= 1'b0;
      rd_reg   <= 1'b0;
      sel_reg  <= 1'b0;
      d_reg    <= 8'h00;
      o_reject <= 1'b0;
    end else begin
      wr_reg   <= take && !i_req_read && !bad;
      rd_reg   <= take && i_req_read;
      o_reject <= take && !i_req_read && bad;
      if (take) begin
        sel_reg <= i_req_read || i_req_param;
        d_reg   <= out_byte;
      end
    end
  end

  // Read sequencing: strobe, device answer, capture
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg  <= H_IDLE;
      o_rd_valid <= 1'b0;
      o_rd_data  <= 8'h00;
    end else begin
      o_rd_valid <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (take && i_req_read) begin
            state_reg <= H_RD;
          end
        end
        H_RD: begin
          state_reg <= H_CAP;
        end
        H_CAP: begin
          o_rd_valid <= 1'b1;
          // Unanswered read returns an idle bus value of zero
          o_rd_data  <= link.dev_d_oe ? link.dev_d : 8'h00;
          state_reg  <= H_IDLE;
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign link.wr               = wr_reg;
  assign link.rd               = rd_reg;
  assign link.cmd_param_select = sel_reg;
  assign link.host_d           = d_reg;
  assign link.host_d_oe        = wr_reg;
endmodule // panel_cmd_host
`default_nettype wire

// ==== testbench/panel_cmd_props.sv ====
// Concurrent checks on the command link between host end and decoder end
`timescale 1ns/1ps
`default_nettype none
module panel_cmd_props (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_cmd_param_select,
  input wire logic [7:0] i_host_d,
  input wire logic       i_host_d_oe,
  input wire logic [7:0] i_dev_d,
  input wire logic       i_dev_d_oe
);
  logic       armed_reg;
  logic [1:0] ans_reg;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Any new command byte restarts the answer count, so stale status never leaks
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      armed_reg <= 1'b0;
      ans_reg   <= 2'h0;
    end else if (i_wr && !i_cmd_param_select) begin
      armed_reg <= (i_host_d == panel_cmd_pkg::CMD_STATUS_READ);
      ans_reg   <= 2'h0;
    end else if (i_dev_d_oe && ans_reg != 2'h3) begin
      ans_reg <= ans_reg + 2'h1;
    end
  end

  a_wr_single_pulse: assert property (i_wr |=> !i_wr)
    else $error("write strobe longer than one cycle");
  a_rd_single_pulse: assert property (i_rd |=> !i_rd)
    else $error("read strobe longer than one cycle");
  a_host_oe_tracks_wr: assert property (i_host_d_oe == i_wr)
    else $error("host drive enable not matching write strobe");
  a_rd_select_high: assert property (i_rd |-> i_cmd_param_select && !i_wr)
    else $error("read without parameter select or with write");
  a_dev_oe_cause: assert property (i_dev_d_oe |-> $past(i_rd))
    else $error("device drove data without a read one cycle before");
  a_no_contention: assert property (!(i_dev_d_oe && i_host_d_oe))
    else $error("both ends drive the data bus");
  a_dummy_first: assert property (i_dev_d_oe && ans_reg == 2'h0
                                  |-> i_dev_d == panel_cmd_pkg::STATUS_DUMMY)
    else $error("first status answer is not the dummy byte");
  a_status_gaps: assert property (i_dev_d_oe && ans_reg == 2'h1 |-> i_dev_d[2:1] == 2'h0)
    else $error("unused status bits not zero");
  a_answer_limit: assert property (i_dev_d_oe |-> armed_reg && ans_reg < 2'h2)
    else $error("device answered a read that was not armed");

  cover property (i_dev_d_oe && ans_reg == 2'h1);
  cover property (i_wr && !i_cmd_param_select && i_host_d == panel_cmd_pkg::CMD_REG_LEVEL);
  cover property (i_rd && !armed_reg);
endmodule // panel_cmd_props
`default_nettype wire

// ==== testbench/panel_driver_setup_command_decoder_tb_top.sv ====
// Self-checking bench joining host end and decoder end over the command link
`timescale 1ns/1ps
`default_nettype none
module panel_driver_setup_command_decoder_tb_top;
  logic        i_clk, i_rst_n, req_valid, req_read, req_param, serial_if, display_on;
  logic        ppa, par_sel, sleep_done, wpv, ready, reject, rd_valid, mpv, swap, grgb, vs;
  logic        ref_en, triple, ref_hi, from_g, lut, rbk, sshort, rej;
  logic [7:0]  req_byte, status_src, orient_ctrl, rd_data, oeff, comh, corr, d;
  logic [23:0] wp, mp;
  logic [8:0]  wsp, wsc, wep, wec;
  logic [1:0]  offs;
  logic [4:0]  src, comw, gam, b3, b4;
  logic [9:0]  rv;
  int          fails, checks, cyc;

  panel_cmd_if panel_cmd_if_i ();
  panel_cmd_host panel_cmd_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(panel_cmd_if_i),
    .i_req_valid(req_valid), .i_req_read(req_read), .i_req_param(req_param),
    .i_req_byte(req_byte), .i_serial_if(serial_if), .i_display_on(display_on),
    .o_ready(ready), .o_reject(reject), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  panel_cmd_device panel_cmd_device_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(panel_cmd_if_i),
    .i_pixel_port_active(ppa), .i_parallel_if_sel(par_sel), .i_status_src(status_src),
    .i_sleep_exit_done(sleep_done), .i_orient_ctrl(orient_ctrl), .i_wr_pixel_valid(wpv),
    .i_wr_pixel(wp), .o_mem_pixel_valid(mpv), .o_mem_pixel(mp), .o_orient_eff(oeff),
    .o_rb_swap(swap), .o_gamma_rg_b(grgb), .o_win_start_page(wsp), .o_win_start_col(wsc),
    .o_win_end_page(wep), .o_win_end_col(wec), .o_ext_vsync_mode(vs), .o_main_ref_en(ref_en),
    .o_boost_triple(triple), .o_main_ref_high(ref_hi), .o_src_from_gamma(from_g),
    .o_src_offset(offs), .o_src_code(src), .o_comh_code(comh), .o_comw_code(comw),
    .o_gamma_gen_code(gam), .o_third_boost_code(b3), .o_fourth_boost_code(b4),
    .o_ic_correction(corr), .o_lut_262k(lut), .o_readback_262k(rbk), .o_seq_short(sshort));
  panel_cmd_props panel_cmd_props_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(panel_cmd_if_i.wr),
    .i_rd(panel_cmd_if_i.rd), .i_cmd_param_select(panel_cmd_if_i.cmd_param_select),
    .i_host_d(panel_cmd_if_i.host_d), .i_host_d_oe(panel_cmd_if_i.host_d_oe),
    .i_dev_d(panel_cmd_if_i.dev_d), .i_dev_d_oe(panel_cmd_if_i.dev_d_oe));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task complete_run;
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end

  task chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task put(input logic p, input logic [7:0] b);
    @(negedge i_clk);
    while (ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    req_valid <= 1'b1;
    req_read  <= 1'b0;
    req_param <= p;
    req_byte  <= b;
    @(posedge i_clk);
    req_valid <= 1'b0;
    @(negedge i_clk);
    rej = reject;
  endtask

  // Parameters are packed left-aligned, first byte in the top bits
  task cmd(input logic [7:0] c, input int n, input logic [79:0] v);
    rv = '0;
    put(1'b0, c);
    for (int i = 0; i < n; i++) begin
      put(1'b1, v[79-8*i -: 8]);
      rv[i] = rej;
    end
    // The decoder takes the last byte one edge after the host end does
    @(negedge i_clk);
  endtask

  task rdb(output logic [7:0] q);
    @(negedge i_clk);
    while (ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    req_valid <= 1'b1;
    req_read  <= 1'b1;
    @(posedge i_clk);
    req_valid <= 1'b0;
    req_read  <= 1'b0;
    for (int n = 0; n < 6 && rd_valid !== 1'b1; n++) @(negedge i_clk);
    q = rd_data;
  endtask

  task pix(input logic [23:0] in, input logic [23:0] exp);
    @(posedge i_clk);
    wpv <= 1'b1;
    wp  <= in;
    @(posedge i_clk);
    wpv <= 1'b0;
    @(negedge i_clk);
    chk("pixel valid", {23'h0, mpv}, 24'h000001);
    chk("pixel data", mp, exp);
  endtask

  task sleep_exit;
    @(posedge i_clk);
    sleep_done <= 1'b1;
    @(posedge i_clk);
    sleep_done <= 1'b0;
    @(negedge i_clk);
  endtask

  initial begin
    {i_rst_n, req_valid, req_read, req_param, serial_if, display_on, ppa, sleep_done, wpv} = '0;
    {req_byte, wp, fails, checks, cyc} = '0;
    par_sel = 1'b1;
    status_src = 8'hff;
    orient_ctrl = 8'ha3;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk("window reset", {wsp, wsc, wep[5:0]}, {9'h000, 9'h000, 6'h2f});
    chk("window end col reset", {15'h0, wec}, 24'h00013f);
    chk("vsync reset", {23'h0, vs}, 24'h0);
    // Extra byte would clear the swap if it were not dropped
    cmd(8'hb8, 2, 80'h5d00_0000_0000_0000_0000);
    chk("orient eff", {16'h0, oeff}, {16'h0, (8'ha3 ^ 8'h5d) & 8'hf9});
    chk("swap gamma", {22'h0, swap, grgb}, 24'h3);
    pix(24'h112233, 24'h332211);
    cmd(8'hb8, 1, 80'h0);
    chk("swap gamma off", {22'h0, swap, grgb}, 24'h0);
    pix(24'h112233, 24'h112233);
    cmd(8'hbb, 8, 80'h81a5_02f0_01ff_fe3f_0000);
    chk("window start", {6'h0, wsp, wsc}, {6'h0, 9'h1a5, 9'h0f0});
    chk("window end", {6'h0, wep, wec}, {6'h0, 9'h1ff, 9'h03f});
    cmd(8'hbd, 0, 80'h0);
    chk("vsync enter", {23'h0, vs}, 24'h1);
    cmd(8'hbc, 0, 80'h0);
    chk("vsync exit", {23'h0, vs}, 24'h0);
    cmd(8'hb9, 0, 80'h0);
    rdb(d);
    chk("status dummy", {16'h0, d}, 24'h0);
    rdb(d);
    chk("status byte", {16'h0, d}, 24'h0000f9);
    rdb(d);
    chk("status third", {16'h0, d}, 24'h0);
    @(posedge i_clk);
    ppa <= 1'b1;
    cmd(8'hb9, 0, 80'h0);
    rdb(d);
    rdb(d);
    chk("status no-op", {16'h0, d}, 24'h0);
    @(posedge i_clk);
    par_sel <= 1'b0;
    status_src <= 8'h91;
    cmd(8'hb9, 0, 80'h0);
    rdb(d);
    rdb(d);
    chk("status serial", {16'h0, d}, 24'h000091);
    cmd(8'hbe, 10, 80'h07a3_961f_0a11_12ff_ffff);
    chk("reg accepted", {14'h0, rv}, 24'h0);
    chk("reg pending", {15'h0, ref_en, comh}, 24'h0);
    sleep_exit();
    chk("reg p1", {21'h0, ref_en, triple, ref_hi}, 24'h7);
    chk("reg p2", {16'h0, from_g, offs, src}, {16'h0, 1'b1, 2'b01, 5'h0a});
    chk("reg levels", {comh, comw, gam, b3[0], b4[0]}, {8'h96, 5'h1f, 5'h0a, 2'b10});
    chk("reg boost", {14'h0, b3, b4}, {14'h0, 5'h11, 5'h12});
    // A refused byte keeps its slot free, so 20h is the next comh value
    cmd(8'hbe, 5, 80'h050d_9720_0a00_0000_0000);
    chk("reg range", {14'h0, rv}, 24'h000004);
    @(posedge i_clk);
    display_on <= 1'b1;
    put(1'b1, 8'h11);
    chk("reg display on", {23'h0, rej}, 24'h1);
    @(posedge i_clk);
    display_on <= 1'b0;
    cmd(8'hbe, 2, 80'h0560_0000_0000_0000_0000);
    chk("reg offset 11", {14'h0, rv}, 24'h2);
    sleep_exit();
    chk("reg p1 double", {21'h0, ref_en, triple, ref_hi}, 24'h4);
    chk("reg p2 own", {16'h0, from_g, src}, 24'h00000d);
    chk("reg comh in range", {16'h0, comh}, 24'h000020);
    cmd(8'hc0, 3, 80'h5511_0100_0000_0000_0000);
    chk("module corr par", {16'h0, corr}, 24'h00000e);
    chk("module bits", {21'h0, lut, rbk, sshort}, 24'h6);
    @(posedge i_clk);
    serial_if <= 1'b1;
    cmd(8'hc0, 2, 80'h0);
    chk("module corr ser", {16'h0, corr}, 24'h00000f);
    chk("module bits clr", {22'h0, lut, rbk}, 24'h0);
    complete_run();
  end
endmodule // panel_driver_setup_command_decoder_tb_top
`default_nettype wire
